// ===== stil_mcu_model.sv
// Microcontroller model: SPI frames that may read interrupt status, and an interrupt input.
`timescale 1ns/1ps
module stil_mcu_model (
	input wire logic clk_i,
	input wire logic int_n_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic stat_read_o
);
	int n_fall = 0;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		stat_read_o = 1'b0;
	end
	// Falling edges are counted, as an edge-triggered host would see them.
	always @(negedge int_n_i) begin
		n_fall++;
	end
	// The link clock stands low outside frames.
	// The read flag outlives chip select so that the synchronised rise still sees it.
	task automatic xfer(input logic rd);
		@(negedge clk_i);
		cs_n_o = 1'b0;
		stat_read_o = rd;
		// The offset keeps every link edge clear of the sampling clock edge.
		#302;
		repeat (8) begin
			sclk_o = 1'b1;
			#62.5;
			sclk_o = 1'b0;
			#62.5;
		end
		@(negedge clk_i);
		cs_n_o = 1'b1;
		repeat (6) @(negedge clk_i);
		stat_read_o = 1'b0;
	endtask
endmodule // stil_mcu_model

// ===== stil_pin_fsm.sv
// Interrupt pin sequencer for the static and dynamic assertion schemes.
`timescale 1ns/1ps
module stil_pin_fsm (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	stil_pin_if.fsm pin
);
	import stil_pkg::*;

	stil_pin_state_type st_r;
	stil_pin_state_type st_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			ST_IDLE: begin
				if (pin.pending) begin
					st_nxt = ST_LOW;
					cnt_nxt = ACT_CYC - 9'h001;
				end
			end
			ST_LOW: begin
				if (pin.read_done) begin
					st_nxt = ST_HOLD;
					cnt_nxt = IDLE_CYC - 9'h001;
				end else if (pin.dyn_scheme) begin
					if (cnt_r == 9'h000) begin
						st_nxt = ST_INACT;
						cnt_nxt = INACT_CYC - 9'h001;
					end else begin
						cnt_nxt = cnt_r - 9'h001;
					end
				end
			end
			ST_INACT: begin
				if (pin.read_done) begin
					st_nxt = ST_HOLD;
					cnt_nxt = IDLE_CYC - 9'h001;
				end else if (cnt_r == 9'h000) begin
					st_nxt = ST_LOW;
					cnt_nxt = ACT_CYC - 9'h001;
				end else begin
					cnt_nxt = cnt_r - 9'h001;
				end
			end
			ST_HOLD: begin
				// The window lets the pull-up restore the line so the next edge is seen.
				if (cnt_r == 9'h000) begin
					st_nxt = ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 9'h001;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
				cnt_nxt = 9'h000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r <= ST_IDLE;
			cnt_r <= 9'h000;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign pin.pin_low = (st_r == ST_LOW);

	a_pend_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r == ST_IDLE && pin.pending) |=> pin.pin_low)
		else $error("pending status did not pull the pin low");
	a_static_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(pin.pin_low && !pin.dyn_scheme && !pin.read_done) |=> pin.pin_low)
		else $error("static pin released without a status read");
	a_pin_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(pin.pin_low && pin.read_done) |=> !pin.pin_low [*8])
		else $error("pin not released after status read");
	a_no_reassert: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r == ST_INACT && pin.read_done) |=> !pin.pin_low [*8])
		else $error("pin driven low again after read in high window");
	a_dyn_toggle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(pin.pin_low && pin.dyn_scheme && !pin.read_done && cnt_r == 9'h000) |=> st_r == ST_INACT)
		else $error("dynamic pin did not go high after the active window");
	a_idle_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r == ST_HOLD && cnt_r != 9'h000) |=> !pin.pin_low)
		else $error("pin asserted inside the idle window");
endmodule // stil_pin_fsm

// ===== stil_pin_if.sv
// Interface between the status logic and the interrupt pin sequencer.
`timescale 1ns/1ps
interface stil_pin_if;
	logic pending;
	logic read_done;
	logic dyn_scheme;
	logic pin_low;
	modport ctl (output pending, output read_done, output dyn_scheme, input pin_low);
	modport fsm (input pending, input read_done, input dyn_scheme, output pin_low);
endinterface

// ===== stil_pkg.sv
// Shared constants and types for the switch threshold and interrupt pin logic.
package stil_pkg;
	localparam int NUM_IN = 24;
	localparam int NUM_SLOT = 5;
	localparam int IND_IN = 12;
	localparam int TRIPLE_LO = 18;
	localparam int LAST_IN = 23;
	localparam int IND_LEVELS = 8;
	localparam int ADC_W = 10;
	localparam int STAT_W = 26;
	localparam int STAT_TW_BIT = 24;
	localparam int STAT_OV_BIT = 25;
	localparam int EDGE_RISE_BIT = 0;
	localparam int EDGE_FALL_BIT = 1;
	localparam int CNT_W = 9;
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_INT_ACTIVE_NS = 2000;
	localparam int IRQ_HIGH_WINDOW_NS = 2000;
	localparam int T_INT_IDLE_NS = 1000;
	localparam int T_CLEAN_NS = 1000;
	localparam logic [CNT_W-1:0] ACT_CYC = CNT_W'((T_INT_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] INACT_CYC =
		CNT_W'((IRQ_HIGH_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] IDLE_CYC = CNT_W'((T_INT_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CLEAN_CYC = CNT_W'((T_CLEAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] WET_0MA = 3'h0;
	localparam logic [2:0] WET_1MA = 3'h1;
	localparam logic [2:0] WET_2MA = 3'h2;
	localparam logic [2:0] WET_5MA = 3'h3;
	localparam logic [2:0] WET_10MA = 3'h4;
	localparam logic [2:0] WET_15MA = 3'h5;
	localparam logic [2:0] WET_RST = WET_0MA;
	localparam logic SCHEME_STATIC = 1'b0;
	localparam logic SCHEME_RST = SCHEME_STATIC;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW = 2'b01,
		ST_INACT = 2'b11,
		ST_HOLD = 2'b10
	} stil_pin_state_type;
endpackage

// ===== stil_top.sv
// Threshold evaluation, event status and interrupt pin control for 24 switch inputs.
`timescale 1ns/1ps
module stil_top (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic stat_read_i,
	input wire logic run_i,
	input wire logic scheme_wr_i,
	input wire logic scheme_i,
	input wire logic [stil_pkg::NUM_IN-1:0] input_mode_i,
	input wire logic [11:0] comparator_level_select_i,
	input wire logic comp_valid_i,
	input wire logic [stil_pkg::NUM_IN-1:0] comp_sample_i,
	input wire logic [2*stil_pkg::NUM_IN-1:0] comp_irq_edge_i,
	input wire logic adc_valid_i,
	input wire logic [4:0] adc_chan_i,
	input wire logic [stil_pkg::ADC_W-1:0] adc_code_i,
	input wire logic [stil_pkg::IND_LEVELS*stil_pkg::ADC_W-1:0] individual_levels_i,
	input wire logic [3*stil_pkg::IND_IN-1:0] level_map_i,
	input wire logic [stil_pkg::ADC_W-1:0] shared_adc_level_i,
	input wire logic [1:0] shared_irq_edge_i,
	input wire logic [stil_pkg::ADC_W-1:0] pair_level_low_i,
	input wire logic [stil_pkg::ADC_W-1:0] pair_level_high_i,
	input wire logic [stil_pkg::ADC_W-1:0] triple_level_low_i,
	input wire logic [stil_pkg::ADC_W-1:0] triple_level_mid_i,
	input wire logic [stil_pkg::ADC_W-1:0] triple_level_high_i,
	input wire logic [stil_pkg::ADC_W-1:0] last_input_level_4_i,
	input wire logic [stil_pkg::ADC_W-1:0] last_input_level_5_i,
	input wire logic [2*stil_pkg::NUM_SLOT*stil_pkg::NUM_IN-1:0] adc_irq_edge_i,
	input wire logic [35:0] wetting_setup_a_i,
	input wire logic [35:0] wetting_setup_b_i,
	input wire logic clean_pulse_polling_i,
	input wire logic clean_high_i,
	input wire logic poll_end_i,
	input wire logic temp_warn_i,
	input wire logic ov_shutdown_i,
	output logic int_pin_o,
	output logic int_pin_oe_o,
	output logic scheme_o,
	output logic [stil_pkg::STAT_W-1:0] int_stat_o,
	output logic [stil_pkg::STAT_W-1:0] stat_snapshot_o,
	output logic [2*stil_pkg::NUM_IN-1:0] comp_level_o,
	output logic [3*stil_pkg::NUM_IN-1:0] wetting_sel_o,
	output logic clean_pulse_o,
	output logic [2:0] clean_level_o
);
	import stil_pkg::*;

	localparam int NB = NUM_IN * NUM_SLOT;

	stil_pin_if pin_if ();

	logic [2:0] sclk_sync_r;
	logic [2:0] sclk_sync_nxt;
	logic [2:0] cs_sync_r;
	logic [2:0] cs_sync_nxt;
	logic armed_r;
	logic armed_nxt;
	logic rd_seen_r;
	logic rd_seen_nxt;
	logic [STAT_W-1:0] int_stat_r;
	logic [STAT_W-1:0] int_stat_nxt;
	logic [STAT_W-1:0] snap_r;
	logic [STAT_W-1:0] snap_nxt;
	logic scheme_r;
	logic scheme_nxt;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic snap_take;
	logic read_done;
	logic [STAT_W-1:0] set_vec;
	logic [NB-1:0] above_r;
	logic [NB-1:0] above_nxt;
	logic [NB-1:0] hit;
	logic [NUM_IN-1:0] seen_r;
	logic [NUM_IN-1:0] seen_nxt;
	logic [NUM_IN-1:0] mode_r;
	logic [NUM_IN-1:0] meas;
	logic [2*NUM_IN-1:0] comp_level_r;
	logic [2*NUM_IN-1:0] comp_level_nxt;
	logic [3*NUM_IN-1:0] wet_r;
	logic [3*NUM_IN-1:0] wet_nxt;
	logic [CNT_W-1:0] clean_cnt_r;
	logic [CNT_W-1:0] clean_cnt_nxt;
	logic clean_on_r;
	logic clean_on_nxt;
	logic [2:0] clean_lvl_r;
	logic [2:0] clean_lvl_nxt;

	// Link pins pass three flops; only the later two stages feed edge detection.
	always_comb begin
		sclk_sync_nxt = {sclk_sync_r[1:0], sclk_i};
		cs_sync_nxt = {cs_sync_r[1:0], cs_n_i};
	end

	assign cs_fall = !cs_sync_r[1] && cs_sync_r[2];
	assign cs_rise = cs_sync_r[1] && !cs_sync_r[2];
	assign sclk_rise = sclk_sync_r[1] && !sclk_sync_r[2];
	assign snap_take = armed_r && sclk_rise && !cs_sync_r[1];
	assign read_done = cs_rise && (rd_seen_r || stat_read_i);

	always_comb begin
		armed_nxt = armed_r;
		rd_seen_nxt = rd_seen_r;
		snap_nxt = snap_r;
		if (cs_fall) begin
			armed_nxt = 1'b1;
		end else if (snap_take || cs_rise) begin
			armed_nxt = 1'b0;
		end
		if (snap_take) begin
			snap_nxt = int_stat_r;
		end
		if (cs_rise) begin
			rd_seen_nxt = 1'b0;
		end else if (stat_read_i && !cs_sync_r[1]) begin
			rd_seen_nxt = 1'b1;
		end
		// Only bits shown to software are cleared; a new event in the same cycle survives.
		int_stat_nxt = (int_stat_r & ~(read_done ? snap_r : {STAT_W{1'b0}})) | set_vec;
	end

	// A change of scheme is ignored while the block is running.
	always_comb begin
		scheme_nxt = scheme_r;
		if (scheme_wr_i && !run_i) begin
			scheme_nxt = scheme_i;
		end
	end

	assign set_vec[STAT_TW_BIT] = temp_warn_i;
	assign set_vec[STAT_OV_BIT] = ov_shutdown_i;

	genvar k;
	genvar s;
	for (k = 0; k < NUM_IN; k++) begin : g_in
		logic adc_strobe;
		assign adc_strobe = adc_valid_i && input_mode_i[k] && (adc_chan_i == 5'(k));
		assign meas[k] = input_mode_i[k] ? adc_strobe : comp_valid_i;
		// A mode change drops history; a sample in that cycle only seeds the store.
		assign seen_nxt[k] = (input_mode_i[k] != mode_r[k]) ? meas[k] : (seen_r[k] | meas[k]);
		assign set_vec[k] = |hit[k*NUM_SLOT +: NUM_SLOT];
		assign comp_level_nxt[2*k +: 2] = comparator_level_select_i[2*(k/4) +: 2];
		if (k < IND_IN) begin : g_wa
			assign wet_nxt[3*k +: 3] = (wetting_setup_a_i[3*k +: 3] > WET_15MA) ? WET_0MA :
				wetting_setup_a_i[3*k +: 3];
		end else begin : g_wb
			assign wet_nxt[3*k +: 3] = (wetting_setup_b_i[3*(k-IND_IN) +: 3] > WET_15MA) ? WET_0MA :
				wetting_setup_b_i[3*(k-IND_IN) +: 3];
		end
		for (s = 0; s < NUM_SLOT; s++) begin : g_slot
			localparam bit USED = (k < TRIPLE_LO) ? (s < 2) : ((k < LAST_IN) ? (s < 3) : 1'b1);
			localparam int IX = k * NUM_SLOT + s;
			if (USED) begin : g_used
				logic [ADC_W-1:0] thr;
				logic [1:0] cfg;
				logic strobe;
				logic new_above;
				if (k < IND_IN && s == 0) begin : g_ind
					assign thr = individual_levels_i[level_map_i[3*k +: 3]*ADC_W +: ADC_W];
				end else if (k < IND_IN) begin : g_shr
					assign thr = shared_adc_level_i;
				end else if (k < TRIPLE_LO) begin : g_pair
					assign thr = (s == 0) ? pair_level_low_i : pair_level_high_i;
				end else if (s < 3) begin : g_tri
					assign thr = (s == 0) ? triple_level_low_i :
						((s == 1) ? triple_level_mid_i : triple_level_high_i);
				end else begin : g_last
					assign thr = (s == 3) ? last_input_level_4_i : last_input_level_5_i;
				end
				if (k < IND_IN && s == 1) begin : g_scfg
					assign cfg = shared_irq_edge_i;
					assign strobe = adc_strobe;
				end else if (s == 0) begin : g_s0
					assign cfg = input_mode_i[k] ? adc_irq_edge_i[2*IX +: 2] : comp_irq_edge_i[2*k +: 2];
					assign strobe = meas[k];
				end else begin : g_sn
					assign cfg = adc_irq_edge_i[2*IX +: 2];
					assign strobe = adc_strobe;
				end
				assign new_above = input_mode_i[k] ? (adc_code_i >= thr) : comp_sample_i[k];
				assign above_nxt[IX] = strobe ? new_above : above_r[IX];
				assign hit[IX] = strobe && seen_r[k] && (input_mode_i[k] == mode_r[k]) &&
					((new_above && !above_r[IX] && cfg[EDGE_RISE_BIT]) ||
					(!new_above && above_r[IX] && cfg[EDGE_FALL_BIT]));
			end else begin : g_unused
				assign above_nxt[IX] = 1'b0;
				assign hit[IX] = 1'b0;
			end
		end
	end

	// The cleaning pulse length is fixed; the polling timer lives elsewhere.
	always_comb begin
		clean_cnt_nxt = clean_cnt_r;
		clean_on_nxt = clean_on_r;
		clean_lvl_nxt = clean_lvl_r;
		if (poll_end_i && clean_pulse_polling_i) begin
			clean_cnt_nxt = CLEAN_CYC - 9'h001;
			clean_on_nxt = 1'b1;
			clean_lvl_nxt = clean_high_i ? WET_15MA : WET_10MA;
		end else if (clean_cnt_r != 9'h000) begin
			clean_cnt_nxt = clean_cnt_r - 9'h001;
		end else begin
			clean_on_nxt = 1'b0;
			clean_lvl_nxt = WET_0MA;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sclk_sync_r <= 3'h0;
			cs_sync_r <= 3'h7;
			armed_r <= 1'b0;
			rd_seen_r <= 1'b0;
			int_stat_r <= {STAT_W{1'b0}};
			snap_r <= {STAT_W{1'b0}};
			scheme_r <= SCHEME_RST;
			above_r <= {NB{1'b0}};
			seen_r <= {NUM_IN{1'b0}};
			mode_r <= {NUM_IN{1'b0}};
			comp_level_r <= {2*NUM_IN{1'b0}};
			wet_r <= {NUM_IN{WET_RST}};
			clean_cnt_r <= 9'h000;
			clean_on_r <= 1'b0;
			clean_lvl_r <= WET_0MA;
		end else begin
			sclk_sync_r <= sclk_sync_nxt;
			cs_sync_r <= cs_sync_nxt;
			armed_r <= armed_nxt;
			rd_seen_r <= rd_seen_nxt;
			int_stat_r <= int_stat_nxt;
			snap_r <= snap_nxt;
			scheme_r <= scheme_nxt;
			above_r <= above_nxt;
			seen_r <= seen_nxt;
			mode_r <= input_mode_i;
			comp_level_r <= comp_level_nxt;
			wet_r <= wet_nxt;
			clean_cnt_r <= clean_cnt_nxt;
			clean_on_r <= clean_on_nxt;
			clean_lvl_r <= clean_lvl_nxt;
		end
	end

	assign pin_if.pending = |int_stat_r;
	assign pin_if.read_done = read_done;
	assign pin_if.dyn_scheme = scheme_r;

	stil_pin_fsm u_pin (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin(pin_if.fsm)
	);

	// The pin only ever sinks; the pull-up gives the high level.
	assign int_pin_o = 1'b0;
	assign int_pin_oe_o = pin_if.pin_low;
	assign scheme_o = scheme_r;
	assign int_stat_o = int_stat_r;
	assign stat_snapshot_o = snap_r;
	assign comp_level_o = comp_level_r;
	assign wetting_sel_o = wet_r;
	assign clean_pulse_o = clean_on_r;
	assign clean_level_o = clean_lvl_r;

	a_scheme_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		run_i |=> $stable(scheme_r))
		else $error("scheme changed while running");
	a_snap_capture: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		snap_take |=> snap_r == $past(int_stat_r))
		else $error("status snapshot not captured");
	a_stat_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		read_done |=> (int_stat_r & $past(snap_r) & ~$past(set_vec)) == {STAT_W{1'b0}})
		else $error("status not cleared by read");
	a_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(|set_vec) |=> (int_stat_r & $past(set_vec)) == $past(set_vec))
		else $error("event lost in status");
	a_first_store: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(meas[0] && !seen_r[0]) |-> !set_vec[0])
		else $error("event raised on first sample");
	a_wet_legal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wet_r[2:0] <= WET_15MA && wet_r[71:69] <= WET_15MA)
		else $error("illegal wetting code");
	a_clean_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(poll_end_i && clean_pulse_polling_i) |=> clean_pulse_o && clean_level_o >= WET_10MA)
		else $error("cleaning pulse missing");
endmodule // stil_top

// ===== testbench.sv
// Self-checking bench for the switch threshold and interrupt pin logic.
`timescale 1ns/1ps
module testbench;
	import stil_pkg::*;
	typedef struct packed {logic [2:0] c; logic [1:0] s; logic [2:0] e;} stil_row_type;
	stil_row_type rows [8] = '{'{3'h0, 2'h0, 3'h0}, '{3'h1, 2'h1, 3'h1}, '{3'h2, 2'h2, 3'h2},
		'{3'h3, 2'h3, 3'h3}, '{3'h4, 2'h0, 3'h4}, '{3'h5, 2'h1, 3'h5}, '{3'h6, 2'h2, 3'h0},
		'{3'h7, 2'h3, 3'h0}};
	logic clk_i, sys_rst_i, run_i, scheme_wr_i, scheme_i, comp_valid_i, adc_valid_i;
	logic clean_pulse_polling_i, clean_high_i, poll_end_i, temp_warn_i, ov_shutdown_i;
	logic sclk_i, cs_n_i, stat_read_i, int_pin_o, int_pin_oe_o, scheme_o, clean_pulse_o;
	logic [4:0] adc_chan_i;
	logic [1:0] shared_irq_edge_i;
	logic [2:0] clean_level_o;
	logic [11:0] comparator_level_select_i;
	logic [35:0] level_map_i, wetting_setup_a_i, wetting_setup_b_i;
	logic [NUM_IN-1:0] input_mode_i, comp_sample_i;
	logic [ADC_W-1:0] adc_code_i, shared_adc_level_i, pair_level_low_i, pair_level_high_i;
	logic [ADC_W-1:0] triple_level_low_i, triple_level_mid_i, triple_level_high_i;
	logic [ADC_W-1:0] last_input_level_4_i, last_input_level_5_i;
	logic [79:0] individual_levels_i;
	logic [47:0] comp_irq_edge_i, comp_level_o;
	logic [239:0] adc_irq_edge_i;
	logic [STAT_W-1:0] int_stat_o, stat_snapshot_o;
	logic [71:0] wetting_sel_o;
	// The pull-up holds the line high whenever nobody drives it.
	wire int_n = int_pin_oe_o ? int_pin_o : 1'b1;
	int fail_count = 0;
	int n_tests = 0;
	int n, f;
	stil_top dut_u (.clk_i, .sys_rst_i, .sclk_i, .cs_n_i, .stat_read_i, .run_i, .scheme_wr_i,
		.scheme_i, .input_mode_i, .comparator_level_select_i, .comp_valid_i, .comp_sample_i,
		.comp_irq_edge_i, .adc_valid_i, .adc_chan_i, .adc_code_i, .individual_levels_i,
		.level_map_i, .shared_adc_level_i, .shared_irq_edge_i, .pair_level_low_i,
		.pair_level_high_i, .triple_level_low_i, .triple_level_mid_i, .triple_level_high_i,
		.last_input_level_4_i, .last_input_level_5_i, .adc_irq_edge_i, .wetting_setup_a_i,
		.wetting_setup_b_i, .clean_pulse_polling_i, .clean_high_i, .poll_end_i, .temp_warn_i,
		.ov_shutdown_i, .int_pin_o, .int_pin_oe_o, .scheme_o, .int_stat_o, .stat_snapshot_o,
		.comp_level_o, .wetting_sel_o, .clean_pulse_o, .clean_level_o);
	stil_mcu_model mcu_u (.clk_i, .int_n_i(int_n), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
		.stat_read_o(stat_read_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic finish_test();
		$display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// A strobe is lowered one edge before it may rise again.
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask
	task automatic adc(input logic [4:0] ch, input logic [9:0] code);
		adc_chan_i = ch;
		adc_code_i = code;
		pulse(adc_valid_i);
	endtask
	// Counts cycles until the pin drive reaches v; an exhausted bound ends the run.
	task automatic wait_oe(input logic v, input int lim);
		n = 0;
		while (int_pin_oe_o !== v) begin
			if (n >= lim) begin
				fail_count++;
				$display("FAIL at %0t: pin wait ran out", $time);
				finish_test();
			end
			tick(1);
			n++;
		end
	endtask
	task automatic near(input int exp);
		chk(80'(n >= exp - 1 && n <= exp + 1), 80'h1);
	endtask
	initial begin
		#900000;
		fail_count++;
		$display("FAIL at %0t: run too long", $time);
		finish_test();
	end
	initial begin
		{sys_rst_i, run_i, scheme_wr_i, scheme_i, comp_valid_i, adc_valid_i} = 6'h20;
		{clean_pulse_polling_i, clean_high_i, poll_end_i, temp_warn_i, ov_shutdown_i} = '0;
		{input_mode_i, comp_sample_i, adc_chan_i, adc_code_i, level_map_i} = '0;
		{comparator_level_select_i, comp_irq_edge_i, adc_irq_edge_i, shared_irq_edge_i} = '0;
		{wetting_setup_a_i, wetting_setup_b_i, individual_levels_i} = '0;
		{pair_level_low_i, pair_level_high_i} = {10'h100, 10'h300};
		{triple_level_low_i, triple_level_mid_i} = {10'h100, 10'h200};
		{triple_level_high_i, last_input_level_4_i} = {10'h300, 10'h380};
		{last_input_level_5_i, shared_adc_level_i} = {10'h3ff, 10'h080};
		tick(6);
		sys_rst_i = 1'b0;
		tick(3);
		chk({int_pin_oe_o, int_stat_o}, '0);
		chk(scheme_o, SCHEME_RST);
		chk(wetting_sel_o, '0);
		chk({clean_pulse_o, clean_level_o}, '0);
		done("reset");
		foreach (rows[i]) begin
			wetting_setup_a_i = {12{rows[i].c}};
			wetting_setup_b_i = {12{rows[i].c}};
			comparator_level_select_i = {6{rows[i].s}};
			tick(2);
			chk(wetting_sel_o, {24{rows[i].e}});
			chk(comp_level_o, {24{rows[i].s}});
		end
		done("level rows");
		comp_irq_edge_i[3:0] = 4'h9;
		comp_sample_i = 24'h000002;
		pulse(comp_valid_i);
		chk(int_stat_o, '0);
		comp_sample_i = 24'h000001;
		pulse(comp_valid_i);
		chk(int_stat_o, 26'h3);
		mcu_u.xfer(1'b1);
		tick(110);
		comp_sample_i = 24'h000002;
		pulse(comp_valid_i);
		chk(int_stat_o, '0);
		done("comparator");
		input_mode_i = 24'h001003;
		individual_levels_i[39:30] = 10'h1f4;
		individual_levels_i[79:70] = 10'h3ff;
		level_map_i[5:0] = 6'h3b;
		{adc_irq_edge_i[122], adc_irq_edge_i[0], shared_irq_edge_i} = 4'hd;
		adc(5'h00, 10'h100);
		adc(5'h01, 10'h010);
		adc(5'h0c, 10'h050);
		chk(int_stat_o, '0);
		adc(5'h00, 10'h1f4);
		adc(5'h01, 10'h100);
		adc(5'h0c, 10'h3ff);
		chk(int_stat_o, 26'h1003);
		mcu_u.xfer(1'b1);
		tick(110);
		done("adc levels");
		pulse(temp_warn_i);
		chk(int_stat_o[24], 1'b1);
		wait_oe(1'b1, 3);
		chk(int_n, 1'b0);
		mcu_u.xfer(1'b0);
		chk(int_pin_oe_o, 1'b1);
		mcu_u.xfer(1'b1);
		chk(stat_snapshot_o[25:24], 2'h1);
		chk({int_pin_oe_o, int_stat_o}, '0);
		pulse(ov_shutdown_i);
		chk(int_stat_o[25], 1'b1);
		wait_oe(1'b1, 150);
		chk(80'(n > 85 && n <= IDLE_CYC), 80'h1);
		mcu_u.xfer(1'b1);
		tick(110);
		done("static pin");
		run_i = 1'b1;
		scheme_i = 1'b1;
		pulse(scheme_wr_i);
		chk(scheme_o, 1'b0);
		run_i = 1'b0;
		pulse(scheme_wr_i);
		chk(scheme_o, 1'b1);
		done("scheme");
		f = mcu_u.n_fall;
		pulse(temp_warn_i);
		wait_oe(1'b1, 3);
		wait_oe(1'b0, 260);
		near(ACT_CYC);
		wait_oe(1'b1, 260);
		near(INACT_CYC);
		chk(mcu_u.n_fall - f, 2);
		mcu_u.xfer(1'b1);
		chk({int_pin_oe_o, int_stat_o}, '0);
		pulse(temp_warn_i);
		wait_oe(1'b1, 120);
		wait_oe(1'b0, 260);
		mcu_u.xfer(1'b1);
		chk(int_stat_o, '0);
		tick(450);
		chk({int_pin_oe_o, 32'(mcu_u.n_fall - f)}, 33'h3);
		done("dynamic pin");
		input_mode_i = 24'h801003;
		{triple_level_low_i, triple_level_mid_i, triple_level_high_i} = {3{10'h2a0}};
		{last_input_level_4_i, last_input_level_5_i} = {2{10'h2a0}};
		adc_irq_edge_i[239:230] = 10'h300;
		adc(5'h17, 10'h100);
		adc(5'h17, 10'h2a0);
		chk(int_stat_o, 26'h800000);
		mcu_u.xfer(1'b1);
		tick(110);
		adc(5'h17, 10'h29f);
		chk(int_stat_o, 26'h800000);
		mcu_u.xfer(1'b1);
		tick(110);
		chk({int_pin_oe_o, int_stat_o}, '0);
		done("single level");
		{clean_pulse_polling_i, clean_high_i} = 2'h3;
		pulse(poll_end_i);
		chk({clean_pulse_o, clean_level_o}, {1'b1, WET_15MA});
		tick(CLEAN_CYC + 1);
		chk({clean_pulse_o, clean_level_o}, '0);
		clean_high_i = 1'b0;
		pulse(poll_end_i);
		chk({clean_pulse_o, clean_level_o}, {1'b1, WET_10MA});
		tick(CLEAN_CYC + 1);
		clean_pulse_polling_i = 1'b0;
		pulse(poll_end_i);
		chk({clean_pulse_o, clean_level_o}, '0);
		done("clean pulse");
		finish_test();
	end
endmodule // testbench
